// [design/gx_expander.v]
// sixteen-line port expander behind a serial two-wire bus target
`timescale 1ns/1ps
`default_nettype none
`include "gx_defines.vh"

module gx_expander (
  input wire ref_clk_i,
  input wire rst_b_i,
  input wire scl_i,
  input wire sda_i,
  output wire sda_o,
  output wire sda_oe_o,
  input wire addr_strap_bit0_i,
  input wire addr_strap_bit1_i,
  input wire addr_strap_bit2_i,
  input wire [7:0] port_lo_pin_i,
  output wire [7:0] port_lo_pin_o,
  output wire [7:0] port_lo_pin_oe_o,
  input wire [7:0] port_hi_pin_i,
  output wire [7:0] port_hi_pin_o,
  output wire [7:0] port_hi_pin_oe_o,
  output wire pullup_en_o,
  output wire alert_n_o,
  output wire alert_oe_o
);

  // ****************************************************************
  // states
  // ****************************************************************
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_RXB = 3'h1;
  localparam [2:0] ST_ACK = 3'h2;
  localparam [2:0] ST_TXB = 3'h3;
  localparam [2:0] ST_RACK = 3'h4;

  // ****************************************************************
  // input synchronisation
  // ****************************************************************
  wire [20:0] raw_in;
  wire [20:0] syn_in;
  wire [15:0] pin_s;
  wire scl_s;
  wire sda_s;
  wire [2:0] strap_s;

  // bus, straps and pins all cross into the local clock; at 40 MHz the
  // fastest bus half period still spans many samples
  assign raw_in = {addr_strap_bit2_i, addr_strap_bit1_i, addr_strap_bit0_i,
                   sda_i, scl_i, port_hi_pin_i, port_lo_pin_i};

  gx_sync #(
    .W(21)
  ) u_sync (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .d_i(raw_in),
    .q_o(syn_in)
  );

  assign pin_s = syn_in[15:0];
  assign scl_s = syn_in[16];
  assign sda_s = syn_in[17];
  assign strap_s = syn_in[20:18];

  // ****************************************************************
  // registers
  // ****************************************************************
  reg scl_d_ff;
  reg sda_d_ff;
  reg [2:0] st_ff;
  reg [3:0] cnt_ff;
  reg [7:0] sh_ff;
  reg [2:0] ptr_ff;
  reg [1:0] ph_ff;
  reg rw_ff;
  reg nack_ff;
  reg sda_oe_ff;
  reg [15:0] out_ff;
  reg [15:0] pol_ff;
  reg [15:0] cfg_ff;
  reg [15:0] snap_ff;
  reg [15:0] pin_o_ff;
  reg [15:0] pin_oe_ff;
  reg alert_oe_ff;
  reg low_ff;
  reg pullup_ff;

  // ****************************************************************
  // bus conditions and read data
  // ****************************************************************
  wire scl_rise;
  wire scl_fall;
  wire bus_start;
  wire bus_stop;
  wire [15:0] in_val;
  wire [63:0] rd_map;
  wire [2:0] nxt_ptr;
  wire ld_first;
  wire ld_next;
  wire ld_any;
  wire [2:0] ld_idx;
  wire [7:0] ld_byte;
  wire addr_hit;
  wire mismatch;

  // edges seen on the synchronised bus lines
  assign scl_rise = scl_s & ~scl_d_ff;
  assign scl_fall = ~scl_s & scl_d_ff;
  assign bus_start = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
  assign bus_stop = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

  // input register shows pins through polarity inversion
  assign in_val = pin_s ^ pol_ff;
  assign rd_map = {cfg_ff, pol_ff, out_ff, in_val};
  // pointer toggles between the two ports of one kind
  assign nxt_ptr = {ptr_ff[2:1], ~ptr_ff[0]};

  // address carries the three strap bits
  assign addr_hit = (sh_ff[7:1] == {`GX_ADDR_PREFIX, strap_s});

  // byte loads for a read: after address ack, or after host ack
  assign ld_first = (st_ff == ST_ACK) & scl_fall & (ph_ff == `GX_PH_ADDR) & rw_ff;
  assign ld_next = (st_ff == ST_RACK) & scl_fall & ~nack_ff;
  assign ld_any = (ld_first | ld_next) & ~bus_start & ~bus_stop;
  assign ld_idx = ld_first ? ptr_ff : nxt_ptr;
  assign ld_byte = rd_map[{ld_idx, 3'h0} +: 8];

  // any input-configured pin away from its held state
  assign mismatch = |((pin_s ^ snap_ff) & cfg_ff);

  // ****************************************************************
  // bus target state machine and register writes
  // ****************************************************************
  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
      st_ff <= ST_IDLE;
      cnt_ff <= 4'h0;
      sh_ff <= 8'h00;
      ptr_ff <= 3'h0;
      ph_ff <= `GX_PH_ADDR;
      rw_ff <= 1'b0;
      nack_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      out_ff <= `GX_OUT_RST;
      pol_ff <= `GX_POL_RST;
      cfg_ff <= `GX_CFG_RST; // all inputs
    end else begin
      scl_d_ff <= scl_s;
      sda_d_ff <= sda_s;
      if (bus_stop) begin
        st_ff <= ST_IDLE;
        sda_oe_ff <= 1'b0;
      end else if (bus_start) begin
        st_ff <= ST_RXB;
        cnt_ff <= 4'h0;
        ph_ff <= `GX_PH_ADDR;
        sda_oe_ff <= 1'b0;
      end else if (ld_any) begin
        sh_ff <= ld_byte;
        ptr_ff <= ld_idx;
        sda_oe_ff <= ~ld_byte[7];
        cnt_ff <= 4'h0;
        ph_ff <= `GX_PH_DATA;
        st_ff <= ST_TXB;
      end else begin
        case (st_ff)
          ST_RXB: begin
            if (scl_rise && cnt_ff != 4'h8) begin
              sh_ff <= {sh_ff[6:0], sda_s};
              cnt_ff <= cnt_ff + 4'h1;
            end else if (scl_fall && cnt_ff == 4'h8) begin
              st_ff <= ST_ACK;
              sda_oe_ff <= 1'b1;
              if (ph_ff == `GX_PH_ADDR) begin
                rw_ff <= sh_ff[0];
                if (!addr_hit) begin
                  st_ff <= ST_IDLE;
                  sda_oe_ff <= 1'b0;
                end
              end else if (ph_ff == `GX_PH_CMD) begin
                ptr_ff <= sh_ff[2:0];
              end else begin
                ptr_ff <= nxt_ptr;
                case (ptr_ff[2:1])
                  `GX_KIND_OUT: begin
                    if (ptr_ff[0]) begin
                      out_ff[15:8] <= sh_ff;
                    end else begin
                      out_ff[7:0] <= sh_ff;
                    end
                  end
                  `GX_KIND_POL: begin
                    if (ptr_ff[0]) begin
                      pol_ff[15:8] <= sh_ff;
                    end else begin
                      pol_ff[7:0] <= sh_ff;
                    end
                  end
                  `GX_KIND_CFG: begin
                    if (ptr_ff[0]) begin
                      cfg_ff[15:8] <= sh_ff;
                    end else begin
                      cfg_ff[7:0] <= sh_ff;
                    end
                  end
                  default: begin
                    ptr_ff <= nxt_ptr; // input register is read only
                  end
                endcase
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              sda_oe_ff <= 1'b0;
              cnt_ff <= 4'h0;
              st_ff <= ST_RXB;
              ph_ff <= (ph_ff == `GX_PH_ADDR) ? `GX_PH_CMD : `GX_PH_DATA;
            end
          end
          ST_TXB: begin
            if (scl_rise) begin
              cnt_ff <= cnt_ff + 4'h1;
            end else if (scl_fall) begin
              if (cnt_ff == 4'h8) begin
                sda_oe_ff <= 1'b0;
                st_ff <= ST_RACK;
              end else begin
                sh_ff <= {sh_ff[6:0], 1'b0};
                sda_oe_ff <= ~sh_ff[6];
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              nack_ff <= sda_s;
            end else if (scl_fall) begin
              st_ff <= ST_IDLE; // host nack ends the read
            end
          end
          default: begin
            sda_oe_ff <= 1'b0;
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // held input state and alert
  // ****************************************************************
  // reading an input register re-arms its port, clearing the alert unless the other port still differs
  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      snap_ff <= `GX_SNAP_RST;
      alert_oe_ff <= 1'b0;
    end else begin
      if (ld_any && ld_idx[2:1] == `GX_KIND_IN) begin
        if (ld_idx[0]) begin
          snap_ff[15:8] <= pin_s[15:8];
        end else begin
          snap_ff[7:0] <= pin_s[7:0];
        end
      end
      // released again as soon as pins return
      alert_oe_ff <= mismatch;
    end
  end

  // ****************************************************************
  // pin drivers
  // ****************************************************************
  // push-pull drive on output lines, released on inputs
  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_o_ff <= `GX_OUT_RST;
      pin_oe_ff <= 16'h0000;
      low_ff <= 1'b0;
      pullup_ff <= 1'b1;
    end else begin
      pin_o_ff <= out_ff;
      pin_oe_ff <= ~cfg_ff;
      low_ff <= 1'b0;
      pullup_ff <= 1'b1;
    end
  end

  // open-drain lines only ever drive low
  assign sda_o = low_ff;
  assign sda_oe_o = sda_oe_ff;
  assign alert_n_o = low_ff;
  assign alert_oe_o = alert_oe_ff;
  assign port_lo_pin_o = pin_o_ff[7:0];
  assign port_lo_pin_oe_o = pin_oe_ff[7:0];
  assign port_hi_pin_o = pin_o_ff[15:8];
  assign port_hi_pin_oe_o = pin_oe_ff[15:8];
  assign pullup_en_o = pullup_ff;

endmodule

`default_nettype wire

// [design/gx_defines.vh]
// constants for the serial-bus sixteen-line port expander
// ****************************************************************
// Behaviour
// - sixteen bus-controlled I/O lines, alert output, weak pull-ups on all lines
// - per port: 8-bit direction, input, output and polarity-inversion registers
// - alert pin is open-drain, active low, only ever pulled low
// - alert asserted while any input pin differs from its held state
// - reset loads register defaults and puts the bus machine in idle
// - after reset all sixteen lines are inputs with pull-ups on
// - bus target address carries three strap pin bits, eight devices per bus
// - serial bus runs up to 400 kHz; host must not exceed it (the bench host runs at 5 MHz unless slowed)
// - output lines are driven push-pull from the output register
// ****************************************************************
`ifndef GX_DEFINES_VH
`define GX_DEFINES_VH

// register index within the command byte, bits [2:1] pick the kind
`define GX_KIND_IN 2'h0
`define GX_KIND_OUT 2'h1
`define GX_KIND_POL 2'h2
`define GX_KIND_CFG 2'h3

// reset values, 16 bits, both ports
`define GX_OUT_RST 16'hffff
`define GX_POL_RST 16'h0000
`define GX_CFG_RST 16'hffff
`define GX_SNAP_RST 16'hffff

// fixed upper four bits of the seven-bit target address
`define GX_ADDR_PREFIX 4'h4

// bus phases
`define GX_PH_ADDR 2'h0
`define GX_PH_CMD 2'h1
`define GX_PH_DATA 2'h2

// timing: fastest bus clock and the local clock
`define GX_SCL_MAX_KHZ 400
`define GX_REF_KHZ 40000
// local clocks per fastest bus half period, rounded down
`define GX_SCL_HALF_CYC ((`GX_REF_KHZ) / (2 * `GX_SCL_MAX_KHZ))

`endif

// [design/gx_sync.v]
// two-flop synchroniser for a vector of asynchronous inputs
`timescale 1ns/1ps
`default_nettype none

module gx_sync #(
  parameter W = 1
) (
  input wire ref_clk_i,
  input wire rst_b_i,
  input wire [W-1:0] d_i,
  output wire [W-1:0] q_o
);

  reg [W-1:0] meta_ff;
  reg [W-1:0] sync_ff;

  // first stage only feeds the second
  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta_ff <= {W{1'b1}};
      sync_ff <= {W{1'b1}};
    end else begin
      meta_ff <= d_i;
      sync_ff <= meta_ff;
    end
  end

  assign q_o = sync_ff;

endmodule

`default_nettype wire

// [testbench/gx_expander_sva.sv]
// checker for the expander pins
`timescale 1ns/1ps
`default_nettype none
module gx_expander_sva (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic addr_strap_bit0_i,
  input wire logic addr_strap_bit1_i,
  input wire logic addr_strap_bit2_i,
  input wire logic [7:0] port_lo_pin_i,
  input wire logic [7:0] port_lo_pin_o,
  input wire logic [7:0] port_lo_pin_oe_o,
  input wire logic [7:0] port_hi_pin_i,
  input wire logic [7:0] port_hi_pin_o,
  input wire logic [7:0] port_hi_pin_oe_o,
  input wire logic pullup_en_o,
  input wire logic alert_n_o,
  input wire logic alert_oe_o
);
  // ****************************************
  // bus and pin properties
  // ****************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  // stop on the wire, all lines driven, inputs at rest
  sequence stop_seen;
    scl_i && $rose(sda_i);
  endsequence
  sequence all_out;
    (&{port_lo_pin_oe_o, port_hi_pin_oe_o}) [*3];
  endsequence
  sequence at_rest;
    ($stable({port_lo_pin_i, port_hi_pin_i, port_lo_pin_oe_o, port_hi_pin_oe_o})
      && !alert_oe_o) [*5];
  endsequence
  AST_SDA_OPEN_DRAIN:
    assert property (!sda_o) else $error("sda data not low");
  AST_ALERT_OPEN_DRAIN:
    assert property (!alert_n_o) else $error("alert data not low");
  AST_PULLUPS_ON:
    assert property (pullup_en_o) else $error("pull-ups off");
  AST_RESET_STATE:
    assert property ($rose(rst_b_i) |-> !(|{port_lo_pin_oe_o, port_hi_pin_oe_o})
      && (&{port_lo_pin_o, port_hi_pin_o}) && !alert_oe_o && !sda_oe_o) else $error("reset state");
  AST_ALL_OUT_QUIET:
    assert property (all_out |-> !alert_oe_o) else $error("alert with no inputs");
  AST_INPUTS_AT_REST:
    assert property (at_rest ##1 $stable({port_lo_pin_i, port_hi_pin_i, port_lo_pin_oe_o,
      port_hi_pin_oe_o}) |-> !alert_oe_o) else $error("alert with inputs at rest");
  AST_SDA_ON_CLOCK_LOW:
    assert property ($changed(sda_oe_o) |-> !$past(scl_i)) else $error("sda moved, clock high");
  AST_RELEASE_AFTER_STOP:
    assert property (stop_seen |-> !sda_oe_o [*8]) else $error("sda driven after stop");
endmodule
bind gx_expander gx_expander_sva i_sva (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .scl_i(scl_i),
  .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .addr_strap_bit0_i(addr_strap_bit0_i),
  .addr_strap_bit1_i(addr_strap_bit1_i), .addr_strap_bit2_i(addr_strap_bit2_i),
  .port_lo_pin_i(port_lo_pin_i), .port_lo_pin_o(port_lo_pin_o),
  .port_lo_pin_oe_o(port_lo_pin_oe_o), .port_hi_pin_i(port_hi_pin_i),
  .port_hi_pin_o(port_hi_pin_o), .port_hi_pin_oe_o(port_hi_pin_oe_o),
  .pullup_en_o(pullup_en_o), .alert_n_o(alert_n_o), .alert_oe_o(alert_oe_o));
`default_nettype wire

// [testbench/gx_host_model.sv]
// serial bus host model, open-drain data
`timescale 1ns/1ps
`default_nettype none
module gx_host_model (
  input wire logic ref_clk_i,
  input wire logic sda_i,
  output var logic scl_o,
  output var logic sda_o
);
  // ****************************************
  // bus cycles
  // ****************************************
  int stretch;
  // idle bus, both lines released
  initial begin
    stretch = 0;
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // quarter bus period, longer when slowed
  task automatic qtr();
    repeat (2 + stretch) @(negedge ref_clk_i);
  endtask
  // start or repeated start
  task automatic start();
    sda_o = 1'b1;
    qtr();
    qtr();
    scl_o = 1'b1;
    qtr();
    sda_o = 1'b0;
    qtr();
    scl_o = 1'b0;
    qtr();
  endtask
  // stop, clock stays high after it
  task automatic stop();
    sda_o = 1'b0;
    qtr();
    scl_o = 1'b1;
    qtr();
    sda_o = 1'b1;
    qtr();
  endtask
  // one bit, sampled mid clock-high
  task automatic xbit(input logic b, output logic r);
    sda_o = b;
    qtr();
    scl_o = 1'b1;
    qtr();
    r = sda_i;
    qtr();
    scl_o = 1'b0;
    qtr();
  endtask
  // eight bits msb first, then the acknowledge bit
  task automatic xbyte(input logic [7:0] d, input logic ai, output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--) xbit(d[i], q[i]);
    xbit(ai, a);
  endtask
  // register write, or pointer write then read with closing nack
  task automatic xfer(input logic [6:0] a, input logic [7:0] c, input logic rd,
      input logic [7:0] d, output logic [7:0] q, output logic [2:0] ak);
    logic [7:0] x;
    logic n;
    start();
    xbyte({a, 1'b0}, 1'b1, x, ak[2]);
    xbyte(c, 1'b1, x, ak[1]);
    if (rd) begin
      start();
      xbyte({a, 1'b1}, 1'b1, x, ak[0]);
      xbyte(8'hff, 1'b1, q, n);
    end else begin
      xbyte(d, 1'b1, q, ak[0]);
    end
    stop();
  endtask
  // two data bytes: write pair, or pointer then read pair, ack then nack
  task automatic xfer2(input logic [6:0] a, input logic [7:0] c, input logic rd,
      input logic [15:0] d, output logic [15:0] q);
    logic [7:0] x;
    logic n;
    start();
    xbyte({a, 1'b0}, 1'b1, x, n);
    xbyte(c, 1'b1, x, n);
    if (rd) begin
      start();
      xbyte({a, 1'b1}, 1'b1, x, n);
      xbyte(8'hff, 1'b0, q[7:0], n);
      xbyte(8'hff, 1'b1, q[15:8], n);
    end else begin
      xbyte(d[7:0], 1'b1, x, n);
      xbyte(d[15:8], 1'b1, x, n);
    end
    stop();
  endtask
endmodule
`default_nettype wire

// [testbench/gx_expander_tb.sv]
// self-checking bench for the port expander
`timescale 1ns/1ps
`default_nettype none
`include "gx_defines.vh"
module gx_expander_tb;
  // ****************************************
  // wiring, checks, scenarios
  // ****************************************
  logic ref_clk_i;
  logic rst_b_i;
  logic [2:0] strap;
  logic [7:0] lo_ext, hi_ext, pol, d, c, q;
  logic [2:0] ak;
  logic [15:0] dd, qq;
  int seed;
  int mismatches;
  int n_tests;
  int cycles = 0;
  wire logic scl, sda_h, sda_oe, sda_d, pull, alert_n, alert_oe;
  wire logic [7:0] lo_o, lo_oe, hi_o, hi_oe;
  // wire levels: data pulled up, pins driven or from outside
  wire logic sda_w = sda_h & ~sda_oe;
  wire logic [7:0] lo_w = (lo_oe & lo_o) | (~lo_oe & lo_ext);
  wire logic [7:0] hi_w = (hi_oe & hi_o) | (~hi_oe & hi_ext);
  gx_expander i_gx_expander (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .scl_i(scl),
    .sda_i(sda_w), .sda_o(sda_d), .sda_oe_o(sda_oe), .addr_strap_bit0_i(strap[0]),
    .addr_strap_bit1_i(strap[1]), .addr_strap_bit2_i(strap[2]), .port_lo_pin_i(lo_w),
    .port_lo_pin_o(lo_o), .port_lo_pin_oe_o(lo_oe), .port_hi_pin_i(hi_w), .port_hi_pin_o(hi_o),
    .port_hi_pin_oe_o(hi_oe), .pullup_en_o(pull), .alert_n_o(alert_n), .alert_oe_o(alert_oe));
  gx_host_model i_gx_host_model (.ref_clk_i(ref_clk_i), .sda_i(sda_w), .scl_o(scl), .sda_o(sda_h));
  // 40 MHz clock and run limit
  initial ref_clk_i = 1'b0;
  always #12.5 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      mismatches = mismatches + 1;
      summarize();
    end
  end
  function automatic logic [6:0] addr_of(input logic [2:0] s);
    return {`GX_ADDR_PREFIX, s};
  endfunction
  function automatic logic [7:0] read_exp(input logic [7:0] pin, input logic [7:0] inv);
    return pin ^ inv;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic [7:0] cmd, input logic rd, input logic [7:0] dat);
    i_gx_host_model.xfer(addr_of(strap), cmd, rd, dat, q, ak);
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // reset, straps, drive, alert, inversion
  initial begin
    seed = 76339;
    mismatches = 0;
    n_tests = 0;
    rst_b_i = 1'b0;
    strap = 3'h0;
    lo_ext = 8'hff;
    hi_ext = 8'hff;
    repeat (16) @(negedge ref_clk_i);
    rst_b_i = 1'b1;
    repeat (4) @(negedge ref_clk_i);
    chk({lo_oe, hi_oe}, 16'h0000);
    chk({lo_o, hi_o}, 16'hffff);
    chk({11'h0, pull, alert_n, alert_oe, sda_oe, sda_d}, 16'h0010);
    $display("test reset done");
    for (int s = 0; s < 8; s++) begin
      strap = s[2:0];
      bus(8'h02, 1'b0, 8'hff);
      chk({13'h0, ak}, 16'h0000);
      i_gx_host_model.xfer(addr_of(~strap), 8'h02, 1'b0, 8'hff, q, ak);
      chk({13'h0, ak}, 16'h0007);
    end
    $display("test address done");
    for (int i = 0; i < 4; i++) begin
      for (int p = 0; p < 2; p++) begin
        c = (i == 3) ? 8'h00 : 8'($random(seed));
        d = 8'($random(seed));
        bus(8'h06 + 8'(p), 1'b0, c);
        bus(8'h02 + 8'(p), 1'b0, d);
        chk(p ? {hi_oe, hi_o} : {lo_oe, lo_o}, {~c, d});
        bus(8'(p), 1'b1, 8'h00);
        chk({8'h0, q}, {8'h0, (d & ~c) | ((p ? hi_ext : lo_ext) & c)});
      end
    end
    $display("test drive done");
    bus(8'h06, 1'b0, 8'hff);
    bus(8'h07, 1'b0, 8'hff);
    bus(8'h00, 1'b1, 8'h00);
    bus(8'h01, 1'b1, 8'h00);
    chk({15'h0, alert_oe}, 16'h0000);
    hi_ext = 8'hff ^ (8'h01 << 3'($random(seed)));
    repeat (5) @(negedge ref_clk_i);
    chk({15'h0, alert_oe}, 16'h0001);
    hi_ext = 8'hff;
    repeat (5) @(negedge ref_clk_i);
    chk({15'h0, alert_oe}, 16'h0000);
    hi_ext = 8'h00;
    repeat (5) @(negedge ref_clk_i);
    chk({15'h0, alert_oe}, 16'h0001);
    bus(8'h01, 1'b1, 8'h00);
    chk({8'h0, q}, 16'h0000);
    chk({15'h0, alert_oe}, 16'h0000);
    $display("test alert done");
    // pointer toggles lo to hi and hi back to lo within a kind; input registers refuse writes
    dd = 16'($random(seed));
    i_gx_host_model.xfer2(addr_of(strap), 8'h02, 1'b0, dd, qq);
    i_gx_host_model.xfer2(addr_of(strap), 8'h00, 1'b0, ~dd, qq);
    chk({hi_o, lo_o}, dd);
    i_gx_host_model.xfer2(addr_of(strap), 8'h03, 1'b1, 16'h0000, qq);
    chk(qq, {dd[7:0], dd[15:8]});
    $display("test pair done");
    i_gx_host_model.stretch = 48;
    for (int p = 0; p < 2; p++) begin
      pol = 8'($random(seed));
      if (p) hi_ext = 8'($random(seed));
      else lo_ext = 8'($random(seed));
      bus(8'h04 + 8'(p), 1'b0, pol);
      bus(8'(p), 1'b1, 8'h00);
      chk({8'h0, q}, {8'h0, read_exp(p ? hi_ext : lo_ext, pol)});
      chk({15'h0, alert_oe}, 16'h0000);
    end
    $display("test polarity done");
    summarize();
  end
endmodule
`default_nettype wire
